// >>> pmw_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - slow RC runs in sleep unless disabled
// R2 - slow crystal only with fast RC
// R3 - select bit picks fast or slow clock
// R4 - select honoured only in fast RC+crystal
// R5 - sleep stops fast clock, crystal keeps running
// R6 - halt enters sleep whatever the select
// R7 - sleep holds core, state retained
// R8 - sleep entry clears watchdog, slow clock counts
// R9 - halt sets sleep flag, clears expired flag
// R10 - four wake sources
// R11 - clear pin wake gives full reset
// R12 - watchdog wake: expired flag, PC/SP reset
// R13 - sleep flag cleared by reset, clear-watchdog
// R14 - port A wake needs enable bit
// R15 - masked interrupt wake resumes after halt
// R16 - enabled interrupt wake takes interrupt; here not while stack_full is high, the core resumes after the halt instead
// R17 - already-set request never wakes
// R18 - start-up wait after any wake
// R19 - software sets crystal low power
// R20 - low power bit clears at reset
// R21 - clock switching free of glitches
module pmw_top #(
	parameter int unsigned POR_CYC = pmw_pkg::POWER_ON_DELAY_CYC
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire pmw_pkg::pmw_axi_req_s axi_req,
	output pmw_pkg::pmw_axi_rsp_s      axi_rsp,
	input  wire pmw_pkg::pmw_core_s    core,
	input  wire logic [7:0]            pa_pin,
	input  wire logic                  ext_clear_pin_n,
	input  wire logic                  fast_tick,
	input  wire logic                  slow_tick,
	output pmw_pkg::pmw_osc_s          osc,
	output logic                       sys_tick,
	output logic                       core_hold,
	output logic                       full_reset,
	output logic                       pc_sp_reset,
	output logic                       irq_take,
	output logic                       wdt_clear,
	output logic                       wdt_run,
	output logic                       sleep_mode,
	output logic                       slow_mode
);
	import pmw_pkg::*;

	typedef struct packed {
		pmw_state_e           st;      // operating mode
		logic [CNT_W-1:0]     cnt;     // delay counter
		pmw_wake_e            cause;   // last wake source
		logic [7:0]           ctrl;    // control_reg_zero
		logic [7:0]           cfg;     // oscillator options
		logic [7:0]           wake_en; // port_a_wake_enable
		logic                 slept;   // sleep_entered_flag
		logic                 tof;     // watchdog_expired_flag
		logic [7:0]           irq_arm; // requests able to wake
		logic [7:0]           pa_s1;   // pin sync, first stage
		logic [7:0]           pa_s2;   // pin sync, second stage
		logic [7:0]           pa_s3;   // previous synced level
		logic                 rst_s1;  // clear pin sync
		logic                 rst_s2;
		logic                 aw_got;  // write address held
		logic                 w_got;   // write data held
		logic [7:0]           aw_addr;
		logic [7:0]           w_data;
		logic                 w_stb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [7:0]           rdata;
		logic [1:0]           rresp;
		logic                 wdt_clr; // one-cycle pulses
		logic                 pcsp;
		logic                 itake;
	} pmw_top_s;

	pmw_top_s         s_ff, nxt_s;
	logic             use_slow;  // effective select
	logic             on_slow;   // source in use
	logic             xtal_cfg;  // fast RC + slow crystal
	logic [7:0]       pa_fall;   // enabled falling edges
	logic [7:0]       irq_hit;   // armed requests
	logic             wdt_hit;   // overflow while counting
	logic [CNT_W-1:0] start_len; // start-up wait length

	// decode shared by the read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADDR_CTRL) || (a == ADDR_CFG) ||
			(a == ADDR_STAT) || (a == ADDR_WAKE);
	endfunction

	function automatic logic [CNT_W-1:0] wait_len(input logic [7:0] c);
		if (c[CFG_OSC_LSB+:2] == OSC_FAST_XTAL) begin
			wait_len = CNT_W'(XTAL_WAIT);
		end else if (c[CFG_RC_SHORT_BIT]) begin
			wait_len = CNT_W'(RC_WAIT_SHORT);
		end else begin
			wait_len = CNT_W'(RC_WAIT_LONG);
		end
	endfunction

	assign xtal_cfg  = s_ff.cfg[CFG_OSC_LSB+:2] == OSC_RC_XTAL;
	assign use_slow  = s_ff.ctrl[CTRL_SEL_BIT] & xtal_cfg; // R4
	assign pa_fall   = s_ff.pa_s3 & ~s_ff.pa_s2 & s_ff.wake_en; // R14
	assign irq_hit   = core.irq_req & s_ff.irq_arm; // R17
	assign wdt_hit   = core.wdt_ovf & wdt_run;
	assign start_len = wait_len(s_ff.cfg);

	// glitch-free source switch, stopped in sleep
	pmw_clk_sel u_sel (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.fast_tick (fast_tick),
		.slow_tick (slow_tick),
		.use_slow  (use_slow),
		.stop      (s_ff.st == ST_SLEEP),
		.sys_tick  (sys_tick),
		.on_slow   (on_slow)
	);

	// next-state logic: bus slave, flags, mode sequencer
	always_comb begin
		nxt_s         = s_ff;
		nxt_s.wdt_clr = 1'b0;
		nxt_s.pcsp    = 1'b0;
		nxt_s.itake   = 1'b0;
		// pins from outside pass two flops first
		nxt_s.pa_s1   = pa_pin;
		nxt_s.pa_s2   = s_ff.pa_s1;
		nxt_s.pa_s3   = s_ff.pa_s2;
		nxt_s.rst_s1  = ext_clear_pin_n;
		nxt_s.rst_s2  = s_ff.rst_s1;

		// write address and data taken in either order
		if (axi_req.awvalid && !s_ff.aw_got && !s_ff.bvalid) begin
			nxt_s.aw_got  = 1'b1;
			nxt_s.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !s_ff.w_got && !s_ff.bvalid) begin
			nxt_s.w_got  = 1'b1;
			nxt_s.w_data = axi_req.wdata[7:0];
			nxt_s.w_stb  = axi_req.wstrb[0];
		end
		if (s_ff.bvalid && axi_req.bready) begin
			nxt_s.bvalid = 1'b0;
		end
		// both halves held: commit, then answer
		if (s_ff.aw_got && s_ff.w_got) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got  = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp  = is_mapped(s_ff.aw_addr) ? RESP_OKAY : RESP_DECERR;
			if (s_ff.w_stb) begin
				case (s_ff.aw_addr)
					ADDR_CTRL: begin
						nxt_s.ctrl = s_ff.w_data & CTRL_MASK; // R3 R19
					end
					ADDR_CFG: begin
						nxt_s.cfg = s_ff.w_data & CFG_MASK;
					end
					ADDR_WAKE: begin
						nxt_s.wake_en = s_ff.w_data;
					end
					default: begin
						nxt_s.bresp = nxt_s.bresp; // status is read-only
					end
				endcase
			end
		end

		// read: one word per request, answered next cycle
		if (s_ff.rvalid && axi_req.rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (axi_req.arvalid && !s_ff.rvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp  = is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_DECERR;
			case (axi_req.araddr)
				ADDR_CTRL: begin
					nxt_s.rdata = s_ff.ctrl;
				end
				ADDR_CFG: begin
					nxt_s.rdata = s_ff.cfg;
				end
				ADDR_STAT: begin
					nxt_s.rdata = {s_ff.cause, s_ff.st != ST_RUN,
						s_ff.st == ST_SLEEP, on_slow, s_ff.tof, s_ff.slept};
				end
				ADDR_WAKE: begin
					nxt_s.rdata = s_ff.wake_en;
				end
				default: begin
					nxt_s.rdata = 8'h00;
				end
			endcase
		end

		// clear-watchdog drops the sleep flag; halt below wins
		if (core.clr_wdt) begin
			nxt_s.slept = 1'b0; // R13
		end

		// mode sequencer
		case (s_ff.st)
			ST_RUN: begin
				// a halt under a held clear pin is ignored altogether
				if (core.halt && s_ff.rst_s2) begin
					nxt_s.st      = ST_SLEEP; // R6
					nxt_s.slept   = 1'b1; // R9
					nxt_s.tof     = 1'b0; // R9
					nxt_s.wdt_clr = 1'b1; // R8
					nxt_s.irq_arm = ~core.irq_req; // R17
				end
			end
			ST_SLEEP: begin
				// wake sources, watchdog first
				if (wdt_hit) begin
					nxt_s.st    = ST_START; // R10
					nxt_s.cause = WK_WDT;
					nxt_s.cnt   = '0;
				end else if (|pa_fall) begin
					nxt_s.st    = ST_START; // R10 R14
					nxt_s.cause = WK_PORT;
					nxt_s.cnt   = '0;
				end else if (|irq_hit) begin
					nxt_s.st      = ST_START; // R10
					nxt_s.cause   = WK_IRQ;
					nxt_s.cnt     = '0;
					nxt_s.irq_arm = irq_hit;
				end
			end
			ST_RSTDLY: begin
				// power-on delay runs on aclk, the oscillator may be cold
				if (s_ff.cnt == CNT_W'(POR_CYC - 1)) begin
					nxt_s.st  = ST_START; // R18
					nxt_s.cnt = '0;
				end else begin
					nxt_s.cnt = s_ff.cnt + CNT_W'(1);
				end
			end
			ST_START: begin
				if (sys_tick) begin
					if (s_ff.cnt == start_len - CNT_W'(1)) begin
						nxt_s.st = ST_RUN; // R18
						if (s_ff.cause == WK_WDT) begin
							nxt_s.tof  = 1'b1; // R12
							nxt_s.pcsp = 1'b1; // R12
						end
						if (s_ff.cause == WK_IRQ && !core.stack_full && // R15
							|(s_ff.irq_arm & core.irq_en)) begin
							nxt_s.itake = 1'b1; // R16
						end
						// otherwise execution resumes after the halt
					end else begin
						nxt_s.cnt = s_ff.cnt + CNT_W'(1);
					end
				end
			end
			default: begin
				nxt_s.st = ST_RUN;
			end
		endcase

		// clear pin low: full reset from any mode, delay restarts
		if (!s_ff.rst_s2) begin
			nxt_s.st    = ST_RSTDLY; // R10 R11
			nxt_s.cnt   = '0;
			nxt_s.cause = WK_RST;
		end
	end

	// state register; power-on values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff         <= '0;
			s_ff.st      <= ST_RUN;
			s_ff.ctrl    <= CTRL_RST; // R20
			s_ff.cfg     <= CFG_RST;
			s_ff.wake_en <= WAKE_RST;
			s_ff.slept   <= 1'b0; // R13
			s_ff.pa_s1   <= 8'hFF;
			s_ff.pa_s2   <= 8'hFF;
			s_ff.pa_s3   <= 8'hFF;
			s_ff.rst_s1  <= 1'b1;
			s_ff.rst_s2  <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// bus answers
	assign axi_rsp.awready = ~s_ff.aw_got & ~s_ff.bvalid;
	assign axi_rsp.wready  = ~s_ff.w_got & ~s_ff.bvalid;
	assign axi_rsp.bvalid  = s_ff.bvalid;
	assign axi_rsp.bresp   = s_ff.bresp;
	assign axi_rsp.arready = ~s_ff.rvalid;
	assign axi_rsp.rvalid  = s_ff.rvalid;
	assign axi_rsp.rdata   = {24'h000000, s_ff.rdata};
	assign axi_rsp.rresp   = s_ff.rresp;

	// oscillators: fast stops in sleep, crystal shares the fast pins
	// fast source also rests once slow mode has taken over; it restarts as
	// soon as the select drops, ahead of the switch back at a slow tick
	assign osc.fast_run = s_ff.st != ST_SLEEP && !(on_slow && use_slow); // R5
	assign osc.xtal_run = xtal_cfg; // R2 R5
	assign osc.rc_run   = ~s_ff.cfg[CFG_SLOW_RC_OFF_BIT]; // R1
	assign osc.xtal_lp  = s_ff.ctrl[CTRL_LP_BIT];

	// watchdog counts in sleep only from a slow source
	assign wdt_run     = s_ff.st != ST_SLEEP || (!s_ff.cfg[CFG_WDT_SYS_BIT] &&
		(osc.rc_run || osc.xtal_run)); // R8
	assign core_hold   = s_ff.st != ST_RUN; // R7
	assign full_reset  = s_ff.st == ST_RSTDLY; // R11
	assign pc_sp_reset = s_ff.pcsp;
	assign irq_take    = s_ff.itake;
	assign wdt_clear   = s_ff.wdt_clr;
	assign sleep_mode  = s_ff.st == ST_SLEEP;
	assign slow_mode   = on_slow;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_halt_sleep: assert property (s_ff.st == ST_RUN && core.halt && s_ff.rst_s2 // R6
		|=> s_ff.st == ST_SLEEP && s_ff.slept && !s_ff.tof && wdt_clear) // R9
		else $error("halt did not enter sleep");
	chk_sleep_stop: assert property (sleep_mode |-> !sys_tick && !osc.fast_run) // R5
		else $error("clock ran in sleep");
	chk_slow_cfg: assert property ($rose(on_slow) |-> $past(use_slow) && xtal_cfg) // R4
		else $error("slow mode outside crystal setup");
	chk_slept_clear: assert property (core.clr_wdt && !(s_ff.st == ST_RUN && core.halt) // R13
		|=> !s_ff.slept)
		else $error("sleep flag not cleared");
	chk_port_wake: assert property (sleep_mode && s_ff.rst_s2 && !wdt_hit && |pa_fall // R14
		|=> s_ff.st == ST_START && s_ff.cause == WK_PORT)
		else $error("port wake missed");
	chk_wdt_wake: assert property (s_ff.st == ST_START && sys_tick && s_ff.rst_s2 && // R12
		s_ff.cause == WK_WDT && s_ff.cnt == start_len - CNT_W'(1)
		|=> pc_sp_reset && s_ff.tof && !core_hold ##1 !pc_sp_reset)
		else $error("watchdog wake wrong");
	chk_clear_pin: assert property (!s_ff.rst_s2 |=> full_reset && s_ff.cnt == '0) // R11
		else $error("clear pin not reset");
	chk_no_early: assert property (sleep_mode ##1 s_ff.st == ST_START |-> // R18
		core_hold [*2])
		else $error("start-up wait too short");
	chk_irq_arm: assert property (sleep_mode && s_ff.rst_s2 && !wdt_hit && !(|pa_fall) // R17
		&& !(|irq_hit) |=> sleep_mode)
		else $error("spurious wake");
	chk_slow_rc_run: assert property (sleep_mode && !s_ff.cfg[CFG_SLOW_RC_OFF_BIT] && // R1
		!s_ff.cfg[CFG_WDT_SYS_BIT] |-> osc.rc_run && wdt_run)
		else $error("slow rc stopped in sleep");

	cov_port_wake: cover property (sleep_mode ##1 s_ff.st == ST_START && s_ff.cause == WK_PORT);
	cov_wdt_wake: cover property (pc_sp_reset);
	cov_irq_take: cover property (irq_take);
	cov_slow_mode: cover property ($rose(on_slow));
endmodule
`default_nettype wire

// >>> pmw_pkg.sv
`default_nettype none
package pmw_pkg;
	// timing: one clock at 125 MHz
	localparam int unsigned CLK_PERIOD_NS      = 8;
	localparam int unsigned POWER_ON_DELAY_US  = 100000;
	localparam int unsigned POWER_ON_DELAY_CYC = POWER_ON_DELAY_US * 1000 / CLK_PERIOD_NS;
	// start-up waits, counted in system clock ticks
	localparam int unsigned RC_WAIT_SHORT      = 2;
	localparam int unsigned RC_WAIT_LONG       = 1024;
	localparam int unsigned XTAL_WAIT          = 1024;
	localparam int unsigned CNT_W              = 24;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG  = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_WAKE = 8'h0C;

	// control_reg_zero fields
	localparam int unsigned CTRL_SEL_BIT = 0;
	localparam int unsigned CTRL_LP_BIT  = 1;
	localparam logic [7:0]  CTRL_MASK    = 8'h03;
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	// oscillator configuration fields
	localparam int unsigned CFG_OSC_LSB         = 0;
	localparam int unsigned CFG_SLOW_RC_OFF_BIT = 2;
	localparam int unsigned CFG_WDT_SYS_BIT     = 3;
	localparam int unsigned CFG_RC_SHORT_BIT    = 4;
	localparam logic [7:0]  CFG_MASK         = 8'h1F;
	localparam logic [7:0]  CFG_RST          = 8'h03;
	localparam logic [7:0]  WAKE_RST         = 8'h00;
	// status fields
	localparam int unsigned STAT_SLEPT_BIT   = 0;
	localparam int unsigned STAT_EXPIRED_BIT = 1;
	localparam int unsigned STAT_SLOW_BIT    = 2;
	localparam int unsigned STAT_SLEEP_BIT   = 3;
	localparam int unsigned STAT_BUSY_BIT    = 4;
	localparam int unsigned STAT_CAUSE_LSB   = 5;

	// oscillator pin configurations
	localparam logic [1:0] OSC_FAST_XTAL = 2'h0;
	localparam logic [1:0] OSC_EXT_RC    = 2'h1;
	localparam logic [1:0] OSC_FAST_RC   = 2'h2;
	localparam logic [1:0] OSC_RC_XTAL   = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [3:0] {
		ST_RUN    = 4'h1,
		ST_SLEEP  = 4'h2,
		ST_RSTDLY = 4'h4,
		ST_START  = 4'h8
	} pmw_state_e;

	typedef enum logic [2:0] {
		WK_NONE = 3'h0,
		WK_RST  = 3'h1,
		WK_PORT = 3'h2,
		WK_IRQ  = 3'h3,
		WK_WDT  = 3'h4
	} pmw_wake_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} pmw_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pmw_axi_rsp_s;

	typedef struct packed {
		logic       halt;
		logic       clr_wdt;
		logic [7:0] irq_req;
		logic [7:0] irq_en;
		logic       stack_full;
		logic       wdt_ovf;
	} pmw_core_s;

	typedef struct packed {
		logic fast_run;
		logic xtal_run;
		logic rc_run;
		logic xtal_lp;
	} pmw_osc_s;
endpackage
`default_nettype wire

// >>> pmw_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
// picks the system tick from the fast or slow oscillator tick
module pmw_clk_sel (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic fast_tick,
	input  wire logic slow_tick,
	input  wire logic use_slow,
	input  wire logic stop,
	output logic      sys_tick,
	output logic      on_slow
);
	typedef struct packed {
		logic cur;  // source in use, 1 = slow
		logic skip; // new source not yet aligned
	} pmw_sel_s;

	pmw_sel_s s_ff, nxt_s;
	logic     cur_tick; // tick of the source in use

	// switching only at a tick of the old source, then dropping the new
	// source's first partial period, keeps every period whole
	always_comb begin
		nxt_s    = s_ff;
		cur_tick = s_ff.cur ? slow_tick : fast_tick;
		sys_tick = cur_tick & ~s_ff.skip & ~stop; // R5 R21
		if (s_ff.skip && cur_tick) begin
			nxt_s.skip = 1'b0;
		end else if (!s_ff.skip && cur_tick && use_slow != s_ff.cur) begin
			nxt_s.cur  = use_slow; // R3 R21
			nxt_s.skip = 1'b1;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign on_slow = s_ff.cur;
endmodule
`default_nettype wire

// >>> pmw_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// oscillator stand-in: fast tick every 2 cycles, slow crystal tick every 7
module pmw_osc_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      fast_tick,
	output logic      slow_tick
);
	logic [2:0] slow_cnt_ff; // slow crystal period counter

	// both sources run free in every mode; gating the system clock is the block's job
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_tick   <= 1'b0;
			slow_tick   <= 1'b0;
			slow_cnt_ff <= 3'h0;
		end else begin
			fast_tick   <= ~fast_tick;
			slow_tick   <= (slow_cnt_ff == 3'h6);
			slow_cnt_ff <= (slow_cnt_ff == 3'h6) ? 3'h0 : slow_cnt_ff + 3'h1;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// one compare: count it, report a mismatch at once
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
	import pmw_pkg::*;
	localparam int unsigned POR = 20; // short clear-pin delay keeps the run brief
	logic         aclk, aresetn;       // 125 MHz clock, sync reset
	pmw_axi_req_s req;                 // bus master side
	pmw_axi_rsp_s rsp;                 // slave answers
	pmw_core_s    core;                // core strobes and levels
	pmw_osc_s     osc;                 // oscillator enables
	logic [7:0]   pa_pin;              // port A pins, idle high
	logic         clr_n, fast_tick, slow_tick, sys_tick, core_hold, full_reset;
	logic         pc_sp_reset, irq_take, wdt_clear, wdt_run, sleep_mode, slow_mode;
	int           error_cnt = 0;       // mismatches
	int           check_count = 0;     // compares made
	int           seed = 32'h4FFC;     // fixed seed
	int           tick_cnt, k;         // start-up ticks, random pin
	logic         hold_d = 1'b0;       // core_hold one cycle back
	logic [33:0]  rd_q[$], note;       // expected {rresp, rdata}
	logic [1:0]   pulse_q[$], pnote;   // expected {pc_sp_reset, irq_take} at resume
	logic [1:0]   b_q[$], bnote;       // expected bresp per write

	pmw_top #(.POR_CYC(POR)) i_pmw_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .core(core), .pa_pin(pa_pin), .ext_clear_pin_n(clr_n),
		.fast_tick(fast_tick), .slow_tick(slow_tick), .osc(osc), .sys_tick(sys_tick),
		.core_hold(core_hold), .full_reset(full_reset), .pc_sp_reset(pc_sp_reset),
		.irq_take(irq_take), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
		.sleep_mode(sleep_mode), .slow_mode(slow_mode));
	pmw_osc_model i_pmw_osc_model (.aclk(aclk), .aresetn(aresetn), .fast_tick(fast_tick),
		.slow_tick(slow_tick));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// watcher: each answer takes the oldest note off its queue
	always @(posedge aclk) begin
		if (rsp.rvalid && req.rready) begin
			note = rd_q.pop_front();
			`CHK("rdata", note, {rsp.rresp, rsp.rdata})
		end
		if (rsp.bvalid && req.bready) begin
			bnote = b_q.pop_front();
			`CHK("bresp", bnote, rsp.bresp)
		end
		if (hold_d && !core_hold) begin
			pnote = pulse_q.pop_front();
			`CHK("resume pulses", pnote, {pc_sp_reset, irq_take})
		end
		if (sleep_mode && sys_tick) `CHK("tick in sleep", 1'b0, sys_tick)
		if (sys_tick && !fast_tick && !slow_tick) `CHK("stray tick", 1'b0, sys_tick)
		if (core_hold && !sleep_mode && !full_reset && sys_tick) tick_cnt++;
		hold_d <= core_hold;
	end

	task automatic stop_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_done, w_done;
		b_q.push_back((a inside {ADDR_CTRL, ADDR_CFG, ADDR_STAT, ADDR_WAKE}) ?
			RESP_OKAY : RESP_DECERR);
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) begin
				aw_done = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (req.wvalid && rsp.wready) begin
				w_done = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask

	// read: note the expected answer, then run the handshake
	task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [7:0] d);
		rd_q.push_back({r, 24'h0, d});
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(posedge aclk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (!rsp.rvalid);
		req.rready <= 1'b0;
	endtask

	// halt instruction; sleep entry seen one cycle later
	task automatic halt_in(input logic wdt_exp, input logic rc_exp);
		@(posedge aclk);
		core.halt <= 1'b1;
		@(posedge aclk);
		core.halt <= 1'b0;
		@(negedge aclk);
		`CHK("sleep_mode", 1'b1, sleep_mode)
		`CHK("core_hold", 1'b1, core_hold)
		`CHK("wdt_clear", 1'b1, wdt_clear)
		`CHK("wdt_run", wdt_exp, wdt_run)
		`CHK("rc_run", rc_exp, osc.rc_run)
		@(posedge aclk);
		tick_cnt = 0;
	endtask

	// wait for the core to resume, bounded; ticks 0 skips the count
	task automatic resume(input int ticks);
		int n;
		n = 0;
		while (core_hold && n < 4000) begin
			@(posedge aclk);
			n++;
		end
		`CHK("core_hold", 1'b0, core_hold)
		if (ticks > 0) `CHK("startup ticks", ticks, tick_cnt)
	endtask

	initial begin
		req = '0;
		core = '0;
		pa_pin = 8'hFF;
		clr_n = 1'b1;
		aresetn = 1'b0;
		tick_cnt = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CTRL, RESP_OKAY, CTRL_RST);
		rd(ADDR_CFG, RESP_OKAY, CFG_RST);
		rd(ADDR_WAKE, RESP_OKAY, WAKE_RST);
		rd(8'h10, RESP_DECERR, 8'h00);
		wr(8'h10, 8'hFF);
		wr(ADDR_STAT, 8'hFF);
		`CHK("xtal_lp", 1'b0, osc.xtal_lp)
		wr(ADDR_CTRL, 8'h02);
		cyc(2);
		`CHK("xtal_lp", 1'b1, osc.xtal_lp)
		// select bit in every oscillator configuration
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CFG, 8'(c));
			wr(ADDR_CTRL, 8'h03);
			cyc(30);
			`CHK("slow_mode", (c == 3), slow_mode)
			`CHK("xtal_run", (c == 3), osc.xtal_run)
			`CHK("fast_run", (c != 3), osc.fast_run)
			rd(ADDR_STAT, RESP_OKAY, (c == 3) ? 8'h04 : 8'h00);
			wr(ADDR_CTRL, 8'h00);
		end
		cyc(30);
		// watchdog wake, short RC start-up
		wr(ADDR_CFG, 8'h13);
		halt_in(1'b1, 1'b1);
		rd(ADDR_STAT, RESP_OKAY, 8'h19);
		pulse_q.push_back(2'b10);
		core.wdt_ovf <= 1'b1;
		@(posedge aclk);
		core.wdt_ovf <= 1'b0;
		resume(RC_WAIT_SHORT);
		rd(ADDR_STAT, RESP_OKAY, 8'h83);
		core.clr_wdt <= 1'b1;
		@(posedge aclk);
		core.clr_wdt <= 1'b0;
		rd(ADDR_STAT, RESP_OKAY, 8'h82);
		// port wake on a random pin; a crystal ignores the short-wait bit
		k = $unsigned($random(seed)) % 8;
		wr(ADDR_CFG, 8'h10);
		wr(ADDR_WAKE, 8'h01 << k);
		halt_in(1'b1, 1'b1);
		pa_pin[(k + 1) % 8] <= 1'b0;
		cyc(10);
		`CHK("sleep_mode", 1'b1, sleep_mode)
		pa_pin <= 8'hFF;
		pulse_q.push_back(2'b00);
		@(posedge aclk);
		pa_pin[k] <= 1'b0;
		resume(XTAL_WAIT);
		pa_pin <= 8'hFF;
		rd(ADDR_STAT, RESP_OKAY, 8'h41);
		rd(ADDR_WAKE, RESP_OKAY, 8'h01 << k);
		// interrupts; watchdog on system clock, slow RC off, halt from slow mode
		wr(ADDR_CFG, 8'h1F);
		wr(ADDR_CTRL, 8'h01);
		core.irq_en <= 8'h02;
		core.irq_req <= 8'h01;
		halt_in(1'b0, 1'b0);
		core.wdt_ovf <= 1'b1;
		@(posedge aclk);
		core.wdt_ovf <= 1'b0;
		core.irq_req <= 8'h00;
		cyc(3);
		core.irq_req <= 8'h01;
		cyc(10);
		`CHK("sleep_mode", 1'b1, sleep_mode)
		pulse_q.push_back(2'b01);
		core.irq_req <= 8'h03;
		resume(0);
		wr(ADDR_CTRL, 8'h00);
		for (int c = 0; c < 2; c++) begin
			core.irq_req <= 8'h00;
			halt_in(1'b0, 1'b0);
			core.irq_en <= c ? 8'h02 : 8'h00;
			core.stack_full <= c[0];
			pulse_q.push_back(2'b00);
			core.irq_req <= 8'h02;
			resume(RC_WAIT_SHORT);
		end
		core.stack_full <= 1'b0;
		rd(ADDR_STAT, RESP_OKAY, 8'h61);
		// clear pin during sleep: reset delay, then long RC start-up
		wr(ADDR_CFG, 8'h03);
		halt_in(1'b1, 1'b1);
		pulse_q.push_back(2'b00);
		clr_n <= 1'b0;
		cyc(6);
		`CHK("full_reset", 1'b1, full_reset)
		`CHK("sleep_mode", 1'b0, sleep_mode)
		clr_n <= 1'b1;
		cyc(POR - 5);
		`CHK("core_hold", 1'b1, core_hold)
		resume(RC_WAIT_LONG);
		stop_test();
	end

	// hang guard, far beyond the expected few thousand cycles
	initial begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
